// [core/dfbp_pkg.sv]
// What this block does
// - select falling edge begins a transaction; rising edge ends it.
// - sample and launch at true/complement clock crossings; complement optional.
// - read bytes change together with each read strobe transition.
// - command, address and data share eight two-way data lines.
// - event output pulled low when an internal event occurred.
// - reset input low: initialise, back to read state, strobe and data undriven.
// - system reset output low during power-on reset, released after set timeout.
// - standby entered immediately when system reset output released.
// - first three clocks carry three command/address words, one byte per edge.
// - one address space regardless of the target-space bit.
// - write address and data go to the command register buffer.
// - reads return array data or overlaid register window data.
// - writes ignore burst type and take one data word.
// - only read data may burst linearly; word-program data is one word.
// - host keeps clocking latency idle cycles before read data moves; write data follows the command words at once.
// - words move high byte on rising edge, low byte on falling edge.
// - host may abort any data transfer by raising select; device accepts.
// - bit 47 read when 1; bit 46 space bit, host sends 0.
// - bit 45 burst type, 0 wrapped, 1 linear.
// - four-bit latency code 0 to 11 gives 5 to 16 clocks; rest reserved.
// - bits 2..0 start word in half-page; upper bits give half-page.
package dfbp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h4;
    localparam logic [3:0] REG_WR_ADDR   = 4'h8;
    localparam logic [3:0] REG_WR_DATA   = 4'hC;
    // ctrl fields
    localparam int CTRL_LAT_LSB    = 0;
    localparam int CTRL_EVT_BIT    = 4;
    localparam int CTRL_POR_BIT    = 5;
    localparam int CTRL_TMO_LSB    = 8;
    localparam logic [3:0]  LAT_RESET     = 4'hB;
    localparam logic [3:0]  LAT_MAX_CODE  = 4'hB;
    localparam logic [4:0]  LAT_BASE      = 5'h05;
    localparam logic [15:0] TMO_RESET     = 16'h0010;
    // status fields
    localparam int ST_WVALID_BIT   = 0;
    localparam int ST_STANDBY_BIT  = 1;
    localparam int ST_BUSY_BIT     = 2;
    localparam int ST_LATERR_BIT   = 3;
    // command/address bit positions
    localparam int CA_RW_BIT       = 47;
    localparam int CA_SPACE_BIT    = 46;
    localparam int CA_BURST_BIT    = 45;
    localparam int CA_HP_MSB       = 37;
    localparam int CA_HP_LSB       = 16;
    localparam int CA_WORD_MSB     = 2;
    localparam int CA_BYTES        = 6;
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ADDR_W          = 25;
endpackage

// [core/dfbp_rd_if.sv]
// read data source seen by the bus port
interface dfbp_rd_if;
    logic [24:0] addr;
    logic [15:0] data;
    modport port (output addr, input data);
    modport src  (input addr, output data);
endinterface

// [core/dfbp_rd_src.sv]
// read data source: a small array stand-in overlaid with a status window
module dfbp_rd_src (
    // clock
    input  wire logic        aclk,
    input  wire logic        aclken,
    // window control
    input  wire logic        overlay_en,
    input  wire logic [15:0] overlay_word,
    // port side
    dfbp_rd_if.src           rd
);
    logic [15:0] mem [0:7];
    logic [15:0] data_reg;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_init
            assign mem[i] = 16'(16'hA500 + i);
        end
    endgenerate

    // reads come from the array or the overlaid window
    always_ff @(posedge aclk) begin
        if (aclken)
            data_reg <= overlay_en ? overlay_word : (mem[rd.addr[2:0]] ^ rd.addr[24:9]);
    end
    assign rd.data = data_reg;
endmodule

// [core/dfbp_top.sv]
module dfbp_top (
    // system
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        aclken,
    // bus pins
    input  wire logic        select_n,
    input  wire logic        bus_clock_true,
    input  wire logic        bus_clock_comp,
    input  wire logic        phase_shift_clock_true,
    input  wire logic        phase_shift_clock_comp,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    output logic             read_data_strobe_out,
    output logic             read_data_strobe_oe,
    input  wire logic        hw_reset_n,
    output logic             event_out_oe,
    output logic             system_reset_out_oe,
    // register bus
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [2:0] {ST_POR, ST_IDLE, ST_CA, ST_LAT, ST_DATA, ST_WAIT} dfbp_state_e;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [5:0] sy1_reg;
    logic [5:0] sy2_reg;
    logic [7:0] dq1_reg;
    logic [7:0] dq2_reg;
    logic       sel_d_reg;
    logic       clk_d_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1_reg <= 6'h3D;
            sy2_reg <= 6'h3D;
            dq1_reg <= 8'h00;
            dq2_reg <= 8'h00;
        end else if (aclken) begin
            sy1_reg <= {select_n, bus_clock_true, bus_clock_comp, hw_reset_n,
                        phase_shift_clock_true, phase_shift_clock_comp};
            sy2_reg <= sy1_reg;
            dq1_reg <= dq_in;
            dq2_reg <= dq1_reg;
        end
    end
    logic sel_n_s;
    logic ck_s;
    logic hwrst_n_s;
    assign sel_n_s   = sy2_reg[5];
    // crossing = true above complement; comp tied to true counts as true alone
    assign ck_s      = sy2_reg[4] & (~sy2_reg[3] | sy2_reg[4] == sy2_reg[3]);
    assign hwrst_n_s = sy2_reg[2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_d_reg <= 1'b1;
            clk_d_reg <= 1'b0;
        end else if (aclken) begin
            sel_d_reg <= sel_n_s;
            clk_d_reg <= ck_s;
        end
    end
    logic sel_fall;
    logic sel_rise;
    logic ck_edge;
    logic ck_rise;
    assign sel_fall = sel_d_reg & ~sel_n_s;
    assign sel_rise = ~sel_d_reg & sel_n_s;
    assign ck_edge  = (clk_d_reg != ck_s) & ~sel_n_s;
    assign ck_rise  = ck_edge & ck_s;

    // ****************************************
    // registers
    // ****************************************
    logic [3:0]  lat_code_reg;
    logic [15:0] tmo_reg;
    logic        evt_set_reg;
    logic        por_req_reg;
    logic [47:0] ca_reg;
    logic [2:0]  ca_cnt_reg;
    logic [24:0] waddr_reg;
    logic [15:0] wdata_reg;
    logic        wvalid_reg;
    logic        lat_err_reg;
    dfbp_state_e state_reg;
    logic [4:0]  lat_cnt_reg;
    logic [24:0] raddr_reg;
    logic        wbyte_reg;
    logic        rd_reg;
    logic        burst_lin_reg;
    logic [15:0] por_cnt_reg;
    logic        dq_oe_reg;
    logic        strobe_reg;
    logic [7:0]  dq_reg;

    dfbp_rd_if rdi ();
    dfbp_rd_src u_src (
        .aclk         (aclk),
        .aclken       (aclken),
        .overlay_en   (lat_err_reg),
        .overlay_word ({12'h000, wvalid_reg, lat_err_reg, 2'b00}),
        .rd           (rdi)
    );
    assign rdi.addr = raddr_reg;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wd_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;
    assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
    assign do_write      = aw_hold_reg & w_hold_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 4'h0;
            wd_reg      <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dfbp_pkg::RESP_OKAY;
        end else if (aclken) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wd_reg     <= s_axi_wdata;
                // strobes travel with the data: the master may change them once w is taken
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == dfbp_pkg::REG_CTRL) ? dfbp_pkg::RESP_OKAY : dfbp_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_code_reg <= dfbp_pkg::LAT_RESET;
            tmo_reg      <= dfbp_pkg::TMO_RESET;
            evt_set_reg  <= 1'b0;
            por_req_reg  <= 1'b0;
        end else if (aclken) begin
            por_req_reg <= 1'b0;
            if (do_write && awaddr_reg == dfbp_pkg::REG_CTRL) begin
                if (wstrb_reg[0]) begin
                    lat_code_reg <= wd_reg[dfbp_pkg::CTRL_LAT_LSB +: 4];
                    evt_set_reg  <= wd_reg[dfbp_pkg::CTRL_EVT_BIT];
                    por_req_reg  <= wd_reg[dfbp_pkg::CTRL_POR_BIT];
                end
                if (wstrb_reg[1])
                    tmo_reg[7:0] <= wd_reg[dfbp_pkg::CTRL_TMO_LSB +: 8];
                if (wstrb_reg[2])
                    tmo_reg[15:8] <= wd_reg[dfbp_pkg::CTRL_TMO_LSB + 8 +: 8];
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            dfbp_pkg::REG_CTRL:    rd_mux = {8'h00, tmo_reg, 2'b00, por_req_reg, evt_set_reg, lat_code_reg};
            dfbp_pkg::REG_STATUS:  rd_mux = {28'h0, lat_err_reg, (state_reg != ST_IDLE),
                                            (state_reg == ST_IDLE), wvalid_reg};
            dfbp_pkg::REG_WR_ADDR: rd_mux = {7'h00, waddr_reg};
            dfbp_pkg::REG_WR_DATA: rd_mux = {16'h0000, wdata_reg};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= dfbp_pkg::RESP_OKAY;
        end else if (aclken) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= dfbp_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // transaction engine
    // ****************************************
    logic do_reset;
    logic [4:0] lat_clocks;
    // reset pin or software power-on request puts the port back to initial state
    assign do_reset   = ~hwrst_n_s | por_req_reg;
    assign lat_clocks = dfbp_pkg::LAT_BASE + {1'b0, lat_code_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= ST_POR;
            ca_reg      <= 48'h0;
            ca_cnt_reg  <= 3'h0;
            lat_cnt_reg <= 5'h00;
            raddr_reg   <= 25'h0;
            rd_reg      <= 1'b0;
            burst_lin_reg <= 1'b0;
            wbyte_reg   <= 1'b0;
            waddr_reg   <= 25'h0;
            wdata_reg   <= 16'h0000;
            wvalid_reg  <= 1'b0;
            lat_err_reg <= 1'b0;
            por_cnt_reg <= 16'h0000;
        end else if (aclken) begin
            if (do_reset) begin
                state_reg   <= ST_POR;
                por_cnt_reg <= 16'h0000;
                wvalid_reg  <= 1'b0;
            end else begin
                case (state_reg)
                    ST_POR: begin
                        por_cnt_reg <= por_cnt_reg + 16'h0001;
                        // release straight into standby
                        if (por_cnt_reg >= tmo_reg)
                            state_reg <= ST_IDLE;
                    end
                    ST_IDLE: if (sel_fall) begin
                        state_reg  <= ST_CA;
                        ca_cnt_reg <= 3'h0;
                    end
                    ST_CA: if (ck_edge) begin
                        ca_reg     <= {ca_reg[39:0], dq2_reg};
                        ca_cnt_reg <= ca_cnt_reg + 3'h1;
                        if (ca_cnt_reg == 3'(dfbp_pkg::CA_BYTES - 1)) begin
                            // space bit ignored: single address space
                            rd_reg    <= ca_reg[dfbp_pkg::CA_RW_BIT - 8];
                            burst_lin_reg <= ca_reg[dfbp_pkg::CA_BURST_BIT - 8];
                            raddr_reg <= {ca_reg[dfbp_pkg::CA_HP_MSB - 8:dfbp_pkg::CA_HP_LSB - 8],
                                          dq2_reg[dfbp_pkg::CA_WORD_MSB:0]};
                            lat_cnt_reg <= 5'h00;
                            wbyte_reg   <= 1'b0;
                            lat_err_reg <= lat_code_reg > dfbp_pkg::LAT_MAX_CODE;
                            // writes carry data straight after the command words
                            state_reg   <= ca_reg[dfbp_pkg::CA_RW_BIT - 8] ? ST_LAT : ST_DATA;
                        end
                    end
                    // count latency on rising edges and leave on the falling edge after the last,
                    // so that the first read byte goes out on a rising edge
                    ST_LAT: if (ck_rise) begin
                        lat_cnt_reg <= lat_cnt_reg + 5'h01;
                    end else if (ck_edge && lat_cnt_reg >= lat_clocks) begin
                        state_reg <= ST_DATA;
                    end
                    ST_DATA: if (ck_edge) begin
                        if (rd_reg) begin
                            if (!ck_s) begin
                                // wrapped bursts stay inside the half-page
                                if (burst_lin_reg)
                                    raddr_reg <= raddr_reg + 25'h1;
                                else
                                    raddr_reg[dfbp_pkg::CA_WORD_MSB:0] <=
                                        raddr_reg[dfbp_pkg::CA_WORD_MSB:0] + 3'h1;
                            end
                        end else if (!wbyte_reg) begin
                            wdata_reg[15:8] <= dq2_reg;
                            wbyte_reg <= 1'b1;
                        end else begin
                            // burst type ignored: one word then wait for select
                            wdata_reg[7:0] <= dq2_reg;
                            waddr_reg  <= raddr_reg;
                            wvalid_reg <= 1'b1;
                            state_reg  <= ST_WAIT;
                        end
                    end
                    ST_WAIT: ;
                    default: state_reg <= ST_IDLE;
                endcase
                if (sel_rise && state_reg != ST_POR)
                    state_reg <= ST_IDLE;
            end
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_oe_reg  <= 1'b0;
            strobe_reg <= 1'b0;
            dq_reg     <= 8'h00;
        end else if (aclken) begin
            if (do_reset || sel_n_s || state_reg != ST_DATA || !rd_reg) begin
                dq_oe_reg  <= 1'b0;
                strobe_reg <= 1'b0;
            end else begin
                dq_oe_reg <= 1'b1;
                if (ck_edge) begin
                    // byte and strobe launched in the same cycle
                    strobe_reg <= ck_s;
                    dq_reg     <= ck_s ? rdi.data[15:8] : rdi.data[7:0];
                end
            end
        end
    end
    assign dq_out               = dq_reg;
    assign dq_oe                = dq_oe_reg;
    assign read_data_strobe_out = strobe_reg;
    assign read_data_strobe_oe  = dq_oe_reg;
    assign event_out_oe         = evt_set_reg | lat_err_reg;
    assign system_reset_out_oe  = (state_reg == ST_POR);
endmodule

// [testbench/dfbp_host_model.sv]
// ****************************************
// bus master stand-in
// ****************************************
module dfbp_host_model (
    // clock
    input  wire logic       aclk,
    // device side
    input  wire logic       dev_oe,
    // bus pins
    output logic            select_n,
    output logic            ck,
    output logic [7:0]      dq,
    // observation
    output int              oe_rise
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] dq_r = 8'h00;
    logic       drv = 1'b0;
    int         rises = 0;

    initial select_n = 1'b1;
    initial ck = 1'b0;
    initial oe_rise = 0;

    // a released line shows the inverse of the last byte, never a stale copy
    assign dq = drv ? dq_r : ~dq_r;

    always @(posedge aclk) if (dev_oe && oe_rise == 0) oe_rise <= rises;

    // one frame; clock stands low outside it, select moves only with clock low
    task automatic xfer(input logic [47:0] ca, input logic [15:0] wd, input int edges);
        rises <= 0;
        oe_rise <= 0;
        select_n <= 1'b0;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < edges; i++) begin
            drv <= i < 6 || !ca[47];
            dq_r <= i < 6 ? ca[47 - 8 * i -: 8] : i == 6 ? wd[15:8] : i == 7 ? wd[7:0] : ~wd[7:0];
            repeat (2) @(posedge aclk);
            if (!ck) rises <= rises + 1;
            ck <= ~ck;
            repeat (2) @(posedge aclk);
        end
        drv <= 1'b0;
        select_n <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// [testbench/dfbp_top_sva.sv]
module dfbp_top_sva (
    // system
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus pins
    input wire logic        select_n,
    input wire logic        bus_clock_true,
    input wire logic        hw_reset_n,
    input wire logic [7:0]  dq_out,
    input wire logic        dq_oe,
    input wire logic        read_data_strobe_out,
    input wire logic        read_data_strobe_oe,
    input wire logic        system_reset_out_oe,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // raw pin count runs ahead of the synchronised one, so the bound stays safe
    logic       ck_q;
    logic [7:0] rise_cnt;
    always_ff @(posedge aclk) ck_q <= bus_clock_true;
    always_ff @(posedge aclk) begin
        if (select_n) rise_cnt <= 8'h00;
        else if (bus_clock_true && !ck_q && rise_cnt != 8'hFF) rise_cnt <= rise_cnt + 8'h01;
    end

    sequence s_por_hold;
        system_reset_out_oe [*8];
    endsequence

    a_oe_pair: assert property (dq_oe == read_data_strobe_oe) else $error("strobe enable differs");
    a_sel_release: assert property (select_n [*5] |-> !dq_oe && !read_data_strobe_oe)
        else $error("pins driven while deselected");
    a_hwrst_hiz: assert property (!hw_reset_n [*4] |-> !dq_oe && !read_data_strobe_oe)
        else $error("pins driven in reset");
    a_hwrst_por: assert property (!hw_reset_n [*4] |-> system_reset_out_oe) else $error("reset out released");
    a_por_len: assert property ($rose(aresetn) |-> s_por_hold ##1 s_por_hold
        ##1 system_reset_out_oe ##1 !system_reset_out_oe) else $error("power-on hold length");
    a_lat_min: assert property (dq_oe && !select_n |-> rise_cnt >= 8'h08) else $error("data before latency");
    a_strobe_edge: assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(read_data_strobe_out))
        else $error("byte moved without strobe");
    a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
    a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
endmodule

bind dfbp_top dfbp_top_sva dfbp_top_sva_i (.*);

// [testbench/dfbp_top_tb.sv]
module dfbp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end

    logic        aclk = 1'b0, aresetn = 1'b0, aclken = 1'b1, hw_reset_n = 1'b1;
    logic        phase_shift_clock_true = 1'b0, phase_shift_clock_comp = 1'b0;
    logic        select_n, bus_clock_true, bus_clock_comp;
    logic [7:0]  dq_in, dq_out, host_dq;
    logic        dq_oe, read_data_strobe_out, read_data_strobe_oe, event_out_oe, system_reset_out_oe;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          mismatches = 0, compares = 0, cycles = 0, oe_rise;

    assign bus_clock_comp = ~bus_clock_true;
    assign dq_in = dq_oe ? dq_out : host_dq;

    dfbp_top dfbp_top_i (.*);
    dfbp_host_model dfbp_host_model_i (.aclk(aclk), .dev_oe(dq_oe), .select_n(select_n), .ck(bus_clock_true),
                                       .dq(host_dq), .oe_rise(oe_rise));

    always #50 aclk = ~aclk;

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er, "write response")
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata & m, e, "register read")
        `CHK(s_axi_rresp, dfbp_pkg::RESP_OKAY, "read response")
        @(posedge aclk);
    endtask

    task automatic wait_por(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (system_reset_out_oe !== 1'b0 && n < 200);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_por();
        int n;
        wait_por(n);
        `CHK(n inside {[17:20]}, 1'b1, "power-on hold length")
        rd_chk(dfbp_pkg::REG_STATUS, 32'h2, 32'h2);
        rd_chk(dfbp_pkg::REG_CTRL, 32'h00FF_FF1F, {8'h00, dfbp_pkg::TMO_RESET, 4'h0, dfbp_pkg::LAT_RESET});
    endtask

    task automatic t_regs();
        axi_wr(dfbp_pkg::REG_CTRL, 32'h00FF_FF1B, 4'h1, dfbp_pkg::RESP_OKAY);
        `CHK(event_out_oe, 1'b1, "event pin")
        rd_chk(dfbp_pkg::REG_CTRL, 32'h00FF_FF1F, 32'h0000_101B);
        axi_wr(dfbp_pkg::REG_CTRL, 32'h0000_100C, 4'hF, dfbp_pkg::RESP_OKAY);
        // the code is judged when a frame's command words end
        dfbp_host_model_i.xfer({3'b100, 45'h3}, 16'h0000, 6);
        rd_chk(dfbp_pkg::REG_STATUS, 32'h8, 32'h8);
        `CHK(event_out_oe, 1'b1, "reserved latency event")
        axi_wr(dfbp_pkg::REG_STATUS, 32'h0, 4'hF, dfbp_pkg::RESP_SLVERR);
        axi_wr(dfbp_pkg::REG_CTRL, 32'h0000_100B, 4'hF, dfbp_pkg::RESP_OKAY);
        dfbp_host_model_i.xfer({3'b100, 45'h3}, 16'h0000, 6);
        `CHK(event_out_oe, 1'b0, "event pin released")
    endtask

    // space and burst flags set on purpose; a trailing word must be ignored
    task automatic t_write();
        logic [47:0] ca;
        ca = {3'b011, 7'h00, 22'h2AB3C5, 13'h0000, 3'h5};
        dfbp_host_model_i.xfer(ca, 16'hA55A, 10);
        rd_chk(dfbp_pkg::REG_WR_ADDR, 32'h01FF_FFFF, {7'h00, ca[37:16], ca[2:0]});
        rd_chk(dfbp_pkg::REG_WR_DATA, 32'h0000_FFFF, 32'h0000_A55A);
        rd_chk(dfbp_pkg::REG_STATUS, 32'h1, 32'h1);
    endtask

    // latency codes 0, 5, 10; bursts cut short after 3, 2, 1 words
    task automatic t_read();
        for (int k = 0; k < 3; k++) begin
            axi_wr(dfbp_pkg::REG_CTRL, 32'h0000_1000 + 32'(5 * k), 4'hF, dfbp_pkg::RESP_OKAY);
            dfbp_host_model_i.xfer({3'b100, 45'h3}, 16'h0000, 16 + 10 * k + 2 * (3 - k));
            `CHK(oe_rise inside {[8 + 5 * k : 9 + 5 * k]}, 1'b1, "read latency")
            `CHK(dq_oe, 1'b0, "bus released")
        end
    endtask

    task automatic t_hwreset();
        int n;
        fork
            dfbp_host_model_i.xfer({3'b100, 45'h3}, 16'h0000, 48);
            begin
                repeat (160) @(posedge aclk);
                hw_reset_n <= 1'b0;
                repeat (5) @(posedge aclk);
                `CHK(dq_oe, 1'b0, "data pins released")
                `CHK(read_data_strobe_oe, 1'b0, "strobe released")
                `CHK(system_reset_out_oe, 1'b1, "reset pin held")
            end
        join
        hw_reset_n <= 1'b1;
        wait_por(n);
        `CHK(n inside {[19:22]}, 1'b1, "reset-out hold after pin reset")
        rd_chk(dfbp_pkg::REG_STATUS, 32'h2, 32'h2);
    endtask

    task automatic results();
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_por();
        t_regs();
        t_write();
        t_read();
        t_hwreset();
        results();
    end
endmodule
